// File: glk_guard_lock.sv
/*
  Guard lock control: actuator teach-in with timeouts, tamper inhibit,
  lock release by the release command, safety channel enables in two
  variants and delayed shutdown after an error warning.
  Assumes power-up is signalled by rst_i and that a retained flag input
  reports whether a tamper inhibit was interrupted by power loss.
*/
// How it works
// - Teach state shows green off, red on, yellow flashing 1 Hz.
// - Ten seconds into teach, yellow switches to 3 Hz power-off request.
// - No power-off within five minutes aborts teach, five red flashes.
// - After power-up the actuator is detected again, then its code stored.
// - Single-teach variant locks the pairing and refuses further teach.
// - Multi-teach variant allows teach to repeat without limit.
// - Teaching a new code invalidates the previously stored code.
// - After teaching, a ten-minute inhibit keeps safety channels off.
// - Green flashes until inhibit expired and the new actuator detected.
// - Power loss during inhibit restarts the full inhibit at power-up.
// - Release command high unlocks the guard.
// - Release command low locks, only with the correct actuator inserted.
// - Unlock-sensitive variant drops both channels on unlock.
// - Unlock-sensitive variant re-enables channels when relocked with actuator.
// - Open-sensitive variant drops channels only when the guard opens.
// - Non-critical error with channels on: warn, diag low, delayed shutdown.
// - Channels drop after the warning stays active thirty minutes.
// - After the cause goes, error is cleared only by opening the guard.
// - Green flashes 1 Hz if a chain input lacks voltage, else steady.
// - A warning clears by itself once its cause is removed.
module glk_guard_lock #(
  parameter logic TEACH_VARIANT = glk_pkg::VAR_MULTI,
  parameter logic OUT_VARIANT = glk_pkg::VAR_UNLOCK,
  parameter int unsigned CODE_W = 16,
  parameter longint unsigned TEACH_REQ_CYC = glk_pkg::TEACH_REQ_CYC,
  parameter longint unsigned TEACH_ABORT_CYC = glk_pkg::TEACH_ABORT_CYC,
  parameter longint unsigned INHIBIT_CYC = glk_pkg::INHIBIT_CYC,
  parameter longint unsigned WARN_CYC = glk_pkg::WARN_CYC,
  parameter longint unsigned SLOW_HALF_CYC = glk_pkg::SLOW_HALF_CYC,
  parameter longint unsigned FAST_HALF_CYC = glk_pkg::FAST_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic individual_coding_i,
  input wire logic [CODE_W-1:0] stored_code_i,
  input wire logic stored_valid_i,
  input wire logic paired_i,
  input wire logic inhibit_pending_i,
  input wire logic actuator_present_i,
  input wire logic [CODE_W-1:0] actuator_code_i,
  input wire logic guard_closed_i,
  input wire logic lock_release_i,
  input wire logic chain_input_a_i,
  input wire logic chain_input_b_i,
  input wire logic noncrit_error_i,
  input wire logic critical_error_i,
  output logic lock_engage_o,
  output logic safety_chan_a_o,
  output logic safety_chan_b_o,
  output logic diag_o,
  output logic led_green_o,
  output logic led_red_o,
  output logic led_yellow_o,
  output logic store_we_o,
  output logic [CODE_W-1:0] store_code_o,
  output logic store_valid_o,
  output logic store_paired_o,
  output logic inhibit_pending_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int unsigned NS = 8;
  glk_sync_if #(.N(NS)) sif ();

  assign sif.raw = {critical_error_i, noncrit_error_i, chain_input_b_i,
                    chain_input_a_i, lock_release_i, guard_closed_i,
                    actuator_present_i, 1'b0};

  glk_sync #(.N(NS)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .s(sif.sync)
  );

  logic act_in, closed_in, release_in, cha_in, chb_in, nce_in, crit_in;
  assign act_in = sif.clean[1];
  assign closed_in = sif.clean[2];
  assign release_in = sif.clean[3];
  assign cha_in = sif.clean[4];
  assign chb_in = sif.clean[5];
  assign nce_in = sif.clean[6];
  assign crit_in = sif.clean[7];

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    glk_pkg::glk_state_t st;
    logic started;                        // Power-up capture done
    logic [glk_pkg::TW-1:0] tmr;          // Sequence timer
    logic [glk_pkg::TW-1:0] wtmr;         // Warning timer
    logic [glk_pkg::TW-1:0] slow;         // Slow flash divider
    logic [glk_pkg::TW-1:0] fast;         // Fast flash divider
    logic slow_ph;
    logic fast_ph;
    logic [3:0] flashes;                  // Red flash edges left in abort
    logic seen;                           // Actuator seen since inhibit start
    logic [CODE_W-1:0] code;              // Active taught code
    logic code_ok;
    logic paired;
    logic pend;                           // Inhibit running, kept across power
    logic locked;
    logic enable;
    logic warn;
    logic err_latch;                      // Shut down, cleared by opening
    logic was_closed;
    logic store_we;
    logic sval;                           // Valid flag offered to the store
    logic diag;
    logic g;
    logic rd;
    logic y;
  } glk_st_t;

  glk_st_t r;
  glk_st_t next_r;

  logic match;
  logic chains_ok;
  assign match = act_in && r.code_ok && (actuator_code_i == r.code);
  assign chains_ok = cha_in && chb_in;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic allow;
    allow = 1'b0;
    next_r = r;
    next_r.store_we = 1'b0;
    next_r.was_closed = closed_in;

    // Flash dividers
    if (r.slow >= glk_pkg::TW'(SLOW_HALF_CYC - 1)) begin
      next_r.slow = '0;
      next_r.slow_ph = ~r.slow_ph;
    end else begin
      next_r.slow = r.slow + 1'b1;
    end
    if (r.fast >= glk_pkg::TW'(FAST_HALF_CYC - 1)) begin
      next_r.fast = '0;
      next_r.fast_ph = ~r.fast_ph;
    end else begin
      next_r.fast = r.fast + 1'b1;
    end

    if (!r.started) begin
      // Retained values are caught after reset release
      next_r.started = 1'b1;
      next_r.code = stored_code_i;
      next_r.code_ok = stored_valid_i;
      next_r.paired = paired_i;
      next_r.pend = inhibit_pending_i;
      next_r.tmr = '0;
      if (inhibit_pending_i) begin
        next_r.st = glk_pkg::GLK_INHIBIT;
      end else if (individual_coding_i && stored_valid_i && !paired_i) begin
        next_r.st = glk_pkg::GLK_CONFIRM;
      end else begin
        next_r.st = glk_pkg::GLK_RUN;
      end
    end else begin
      next_r.tmr = r.tmr + 1'b1;
      unique case (r.st)
        glk_pkg::GLK_RUN: begin
          next_r.tmr = '0;
          // Unknown actuator after power cycle starts teaching
          if (individual_coding_i && act_in && !match && !r.code_ok &&
              !(r.paired && TEACH_VARIANT == glk_pkg::VAR_SINGLE)) begin
            next_r.st = glk_pkg::GLK_TEACH;
          end
        end
        glk_pkg::GLK_TEACH: begin
          if (r.tmr >= glk_pkg::TW'(TEACH_REQ_CYC - 1)) begin
            next_r.tmr = '0;
            next_r.st = glk_pkg::GLK_REQOFF;
            // Candidate code held in storage, old one no longer valid
            next_r.code = actuator_code_i;
            next_r.code_ok = 1'b0;
            next_r.store_we = 1'b1;
          end
        end
        glk_pkg::GLK_REQOFF: begin
          if (r.tmr >= glk_pkg::TW'(TEACH_ABORT_CYC - 1)) begin
            next_r.tmr = '0;
            next_r.flashes = 4'(2 * glk_pkg::BAD_FLASHES);
            next_r.st = glk_pkg::GLK_ABORT;
            next_r.store_we = 1'b1;
          end
        end
        glk_pkg::GLK_ABORT: begin
          if (r.slow_ph != next_r.slow_ph) begin
            if (r.flashes == 4'h0) begin
              next_r.st = glk_pkg::GLK_RUN;
            end else begin
              next_r.flashes = r.flashes - 1'b1;
            end
          end
        end
        glk_pkg::GLK_CONFIRM: begin
          next_r.tmr = '0;
          if (act_in && actuator_code_i == r.code) begin
            next_r.code_ok = 1'b1;
            next_r.paired = 1'b1;
            next_r.pend = 1'b1;
            next_r.seen = 1'b0;
            next_r.store_we = 1'b1;
            next_r.st = glk_pkg::GLK_INHIBIT;
          end
        end
        glk_pkg::GLK_INHIBIT: begin
          if (match) begin
            next_r.seen = 1'b1;
          end
          if (r.tmr >= glk_pkg::TW'(INHIBIT_CYC - 1)) begin
            next_r.tmr = INHIBIT_CYC[glk_pkg::TW-1:0];
            if (r.pend) begin
              next_r.pend = 1'b0;
              next_r.store_we = 1'b1;
            end
            if (r.seen || match) begin
              next_r.st = glk_pkg::GLK_RUN;
            end
          end
        end
        default: begin
          next_r.st = glk_pkg::GLK_RUN;
        end
      endcase
    end

    // Lock follows the release command, engages only on the right actuator
    if (release_in) begin
      next_r.locked = 1'b0;
    end else if (match && closed_in) begin
      next_r.locked = 1'b1;
    end

    // Warning follows its cause; timer runs while it stands
    next_r.warn = nce_in && (r.enable || r.warn);
    if (!next_r.warn) begin
      next_r.wtmr = '0;
    end else if (r.wtmr < glk_pkg::TW'(WARN_CYC)) begin
      next_r.wtmr = r.wtmr + 1'b1;
    end
    if ((r.warn && r.wtmr >= glk_pkg::TW'(WARN_CYC - 1)) || crit_in) begin
      next_r.err_latch = 1'b1;
    end else if (!closed_in && r.was_closed && !nce_in) begin
      next_r.err_latch = 1'b0;
    end

    // Enable decision, one value for both channels
    if (OUT_VARIANT == glk_pkg::VAR_UNLOCK) begin
      allow = next_r.locked && match;
    end else begin
      allow = closed_in && match;
    end
    next_r.enable = allow && r.started && !next_r.err_latch && !crit_in &&
                    chains_ok && (r.st == glk_pkg::GLK_RUN);
    next_r.diag = next_r.enable && !next_r.warn;
    // Candidate counts as valid while the power-off request stands
    next_r.sval = next_r.code_ok || (next_r.st == glk_pkg::GLK_REQOFF);

    // Indicators
    unique case (r.st)
      glk_pkg::GLK_TEACH: begin
        next_r.g = 1'b0;
        next_r.rd = 1'b1;
        next_r.y = r.slow_ph;
      end
      glk_pkg::GLK_REQOFF: begin
        next_r.g = 1'b0;
        next_r.rd = 1'b1;
        next_r.y = r.fast_ph;
      end
      glk_pkg::GLK_ABORT: begin
        next_r.g = 1'b0;
        next_r.rd = r.flashes[0];
        next_r.y = 1'b0;
      end
      glk_pkg::GLK_INHIBIT, glk_pkg::GLK_CONFIRM: begin
        next_r.g = r.slow_ph;
        next_r.rd = 1'b0;
        next_r.y = 1'b0;
      end
      default: begin
        next_r.g = chains_ok ? 1'b1 : r.slow_ph;
        next_r.rd = (r.warn || r.err_latch) ? r.slow_ph : 1'b0;
        next_r.y = next_r.locked ? 1'b1 : (closed_in ? r.slow_ph : 1'b0);
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Reset stands for power-up: retained state is reloaded afterwards
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.st <= glk_pkg::GLK_RUN;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // Both channels from the same flop so they can never disagree
  assign safety_chan_a_o = r.enable;
  assign safety_chan_b_o = r.enable;
  assign lock_engage_o = r.locked;
  assign diag_o = r.diag;
  assign led_green_o = r.g;
  assign led_red_o = r.rd;
  assign led_yellow_o = r.y;
  assign store_we_o = r.store_we;
  assign store_code_o = r.code;
  assign store_valid_o = r.sval;
  assign store_paired_o = r.paired;
  assign inhibit_pending_o = r.pend;

endmodule // glk_guard_lock

// File: glk_pkg.sv
/*
  Package for the guard lock teach and output control block: state codes,
  indicator patterns and timing constants.
  Assumes a 250 MHz clock; long times are scaled to cycle counts in this package.
*/
package glk_pkg;

  // Clock rate
  localparam longint unsigned CLK_HZ = 64'd250_000_000;

  // Times in their own units
  localparam int unsigned TEACH_REQ_S = 10;      // Teach to power-off request
  localparam int unsigned TEACH_ABORT_MIN = 5;   // Wait for power-off
  localparam int unsigned INHIBIT_MIN = 10;      // Tamper inhibit
  localparam int unsigned WARN_MIN = 30;         // Warning to shutdown
  localparam int unsigned SLOW_HZ = 1;           // Slow flash rate
  localparam int unsigned FAST_HZ = 3;           // Short cyclic flash rate
  localparam int unsigned BAD_FLASHES = 5;       // Invalid actuator flashes

  // Cycle counts derived from the rate
  localparam longint unsigned TEACH_REQ_CYC = TEACH_REQ_S * CLK_HZ;
  localparam longint unsigned TEACH_ABORT_CYC = TEACH_ABORT_MIN * 60 * CLK_HZ;
  localparam longint unsigned INHIBIT_CYC = INHIBIT_MIN * 60 * CLK_HZ;
  localparam longint unsigned WARN_CYC = WARN_MIN * 60 * CLK_HZ;
  localparam longint unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_HZ);
  localparam longint unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_HZ);

  // Width of all timer counters
  localparam int unsigned TW = 40;

  // Teach sequence states, one-hot
  typedef enum logic [5:0] {
    GLK_RUN     = 6'h01,  // Normal operation
    GLK_TEACH   = 6'h02,  // Actuator being taught
    GLK_REQOFF  = 6'h04,  // Asking for power removal
    GLK_CONFIRM = 6'h08,  // After power-up, waiting for re-detection
    GLK_ABORT   = 6'h10,  // Teach cancelled, red flashes
    GLK_INHIBIT = 6'h20   // Tamper inhibit running
  } glk_state_t;

  // Teach variants
  localparam logic VAR_SINGLE = 1'b0;
  localparam logic VAR_MULTI = 1'b1;
  // Output variants
  localparam logic VAR_UNLOCK = 1'b0;
  localparam logic VAR_OPEN = 1'b1;

endpackage : glk_pkg

// File: glk_sync_if.sv
/*
  Interface carrying the three-stage pin synchroniser group between the
  top module and its synchroniser.
  Assumes one clock for both ends.
*/
interface glk_sync_if #(parameter int unsigned N = 8);
  logic [N-1:0] raw;
  logic [N-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface : glk_sync_if

// File: glk_sync.sv
/*
  Pin synchroniser: three stages plus an output flip-flop per bit, a change is accepted once the
  second and third stages agree.
  Assumes all inputs are asynchronous to clk_i.
*/
module glk_sync #(
  parameter int unsigned N = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  glk_sync_if.sync s
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] out;
  } glk_sync_st_t;

  glk_sync_st_t r;
  glk_sync_st_t next_r;

  // Stage shift; first stage feeds only the second
  always_comb begin
    next_r = r;
    next_r.s1 = s.raw;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < N; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.out[i] = r.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign s.clean = r.out;

endmodule // glk_sync

// File: glk_guard_lock_assertions.sv
/*
  Checker for the guard lock block, bound to its top module.
  Assumes one clock domain and a synchronous active-high reset.
*/
module glk_guard_lock_chk #(
  parameter longint unsigned WARN_CYC = 30
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic guard_closed_i,
  input wire logic lock_release_i,
  input wire logic noncrit_error_i,
  input wire logic critical_error_i,
  input wire logic stored_valid_i,
  input wire logic lock_engage_o,
  input wire logic safety_chan_a_o,
  input wire logic safety_chan_b_o,
  input wire logic diag_o,
  input wire logic store_we_o,
  input wire logic inhibit_pending_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Slack covers the pin synchroniser plus the output register
  localparam int WLIM = int'(WARN_CYC) + 8;
  ////////////////////////////////////////////////////////////////////////////
  // Run length of the warning cause; saturates so it never wraps
  logic [15:0] wcnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || !noncrit_error_i) begin
      wcnt <= 16'h0000;
    end else if (wcnt != 16'hffff) begin
      wcnt <= wcnt + 16'h0001;
    end
  end
  // A pin level held long enough to pass the synchroniser
  sequence s_held(sig);
    sig[*7];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_CHAN_PAIR: assert property (safety_chan_a_o == safety_chan_b_o)
    else $error("safety channels differ");
  AST_REL_UNLOCK: assert property (s_held(lock_release_i) |-> !lock_engage_o)
    else $error("locked while release held");
  AST_OPEN_NOLOCK: assert property (s_held(!guard_closed_i) |-> !lock_engage_o)
    else $error("locked with guard open");
  AST_UNLOCK_DROP: assert property
    ($past(!lock_engage_o) && !lock_engage_o |-> !safety_chan_a_o)
    else $error("channels on while unlocked");
  AST_WARN_DIAG: assert property (s_held(noncrit_error_i) |-> !diag_o)
    else $error("diag high during warning");
  AST_WARN_SHUT: assert property (int'(wcnt) > WLIM |-> !safety_chan_a_o)
    else $error("channels on after warning time");
  AST_CRIT_DROP: assert property (s_held(critical_error_i) |-> !safety_chan_b_o)
    else $error("channels on with critical error");
  AST_WE_PULSE: assert property (store_we_o |=> !store_we_o)
    else $error("store write longer than one cycle");
  AST_TEACH_OFF: assert property (!stored_valid_i |-> !safety_chan_a_o)
    else $error("channels on without valid code");
  AST_INHIBIT_OFF: assert property (inhibit_pending_o |-> !safety_chan_a_o)
    else $error("channels on during inhibit");
endmodule // glk_guard_lock_chk

bind glk_guard_lock glk_guard_lock_chk #(.WARN_CYC(WARN_CYC)) u_chk (
  .clk_i, .rst_i, .guard_closed_i, .lock_release_i, .noncrit_error_i,
  .critical_error_i, .stored_valid_i, .lock_engage_o, .safety_chan_a_o,
  .safety_chan_b_o, .diag_o, .store_we_o, .inhibit_pending_o
);

// File: glk_monitor.sv
/*
  Model of the dual-channel monitoring controller facing the block.
  Assumes the block's clock; outputs change on the falling edge.
*/
module glk_monitor #(
  parameter int unsigned DLY = 3
) (
  input wire logic clk_i,
  input wire logic rel_req_i,
  input wire logic safety_chan_a_i,
  input wire logic safety_chan_b_i,
  input wire logic diag_i,
  output logic lock_release_o,
  output logic stop_o
);
  logic [7:0] pipe = 8'h00;
  // A slow controller: the release command lags the request by DLY cycles
  always @(negedge clk_i) begin
    pipe <= {pipe[6:0], rel_req_i};
    lock_release_o <= pipe[DLY-1];
  end
  // Diag low with both channels on: wind the process down
  always @(negedge clk_i) begin
    stop_o <= safety_chan_a_i && safety_chan_b_i && !diag_i;
  end
endmodule // glk_monitor

// File: glk_guard_lock_tb.sv
/*
  Self-checking bench for the guard lock block with a monitor model.
  Assumes shortened timers; retained store is modelled here.
*/
module glk_guard_lock_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] CODE_A = 16'h5a3c; // Arbitrary actuator code
  localparam logic [15:0] CODE_B = 16'hc3a5; // Arbitrary actuator code
  localparam int WARN = 30;
  localparam int INH = 40;
  logic clk_i, rst_i, ce_i, individual_coding_i, stored_valid_i, paired_i;
  logic inhibit_pending_i, actuator_present_i, guard_closed_i, rel_req;
  logic chain_input_a_i, chain_input_b_i, noncrit_error_i, critical_error_i;
  logic [15:0] stored_code_i, actuator_code_i, store_code_o;
  logic lock_engage_o, safety_chan_a_o, safety_chan_b_o, diag_o, stop;
  logic led_green_o, led_red_o, led_yellow_o, store_we_o, store_valid_o;
  logic store_paired_o, inhibit_pending_o;
  wire logic lock_release_i;
  int error_cnt = 0;
  int checks = 0;
  int cyc_cnt = 0;
  glk_guard_lock #(.TEACH_REQ_CYC(20), .TEACH_ABORT_CYC(50),
    .INHIBIT_CYC(INH), .WARN_CYC(WARN), .SLOW_HALF_CYC(4),
    .FAST_HALF_CYC(2)) uut (.*);
  glk_monitor #(.DLY(3)) u_mon (.clk_i(clk_i), .rel_req_i(rel_req),
    .safety_chan_a_i(safety_chan_a_o), .safety_chan_b_i(safety_chan_b_o),
    .diag_i(diag_o), .lock_release_o(lock_release_i), .stop_o(stop));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Retained store: keeps whatever the block writes, across power cycles
  always @(negedge clk_i) begin
    if (store_we_o === 1'b1) begin
      stored_code_i <= store_code_o;
      stored_valid_i <= store_valid_o;
      paired_i <= store_paired_o;
      inhibit_pending_i <= inhibit_pending_o;
    end
  end
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(input logic got, input logic exp, input string m);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic chk_code(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t code %h", $time, got);
    end
  endtask
  // Power cycle; a cleared store lets the multi variant teach again
  task automatic pwr(input logic keep);
    rst_i = 1'b1;
    if (!keep) begin
      stored_valid_i = 1'b0;
      paired_i = 1'b0;
    end
    cyc(16);
    rst_i = 1'b0;
    cyc(4);
  endtask
  task automatic wait_chan(input logic v);
    for (int i = 0; i < 80 && safety_chan_a_o !== v; i++) cyc(1);
  endtask
  task automatic wait_we();
    cyc(1);
    for (int i = 0; i < 200 && store_we_o !== 1'b1; i++) cyc(1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_enable();
    wait_chan(1'b1);
    chk(lock_engage_o, 1'b1, "lock");
    chk(led_yellow_o, 1'b1, "yellow locked");
    chk(safety_chan_b_o, 1'b1, "chan b");
    chk(diag_o, 1'b1, "diag");
  endtask
  task automatic t_unlock();
    rel_req = 1'b1;
    wait_chan(1'b0);
    chk(lock_engage_o, 1'b0, "unlock");
    chk(safety_chan_b_o, 1'b0, "chan b off");
    rel_req = 1'b0;
    wait_chan(1'b1);
    chk(safety_chan_b_o, 1'b1, "relock");
  endtask
  task automatic t_wrong();
    rel_req = 1'b1;
    cyc(12);
    actuator_code_i = CODE_B;
    rel_req = 1'b0;
    cyc(20);
    chk(lock_engage_o, 1'b0, "wrong actuator");
    actuator_code_i = CODE_A;
    wait_chan(1'b1);
  endtask
  task automatic t_warn();
    noncrit_error_i = 1'b1;
    cyc(8);
    chk(diag_o, 1'b0, "diag warn");
    chk(stop, 1'b1, "monitor stop");
    cyc(WARN + 4);
    chk(safety_chan_a_o, 1'b0, "warn shutdown");
    noncrit_error_i = 1'b0;
    cyc(10);
    chk(safety_chan_a_o, 1'b0, "latched");
    rel_req = 1'b1;
    cyc(10);
    guard_closed_i = 1'b0;
    cyc(8);
    guard_closed_i = 1'b1;
    rel_req = 1'b0;
    wait_chan(1'b1);
    chk(safety_chan_a_o, 1'b1, "cleared");
    chk(diag_o, 1'b1, "diag back");
  endtask
  task automatic t_green();
    int n = 0;
    logic g;
    chain_input_a_i = 1'b0;
    cyc(8);
    g = led_green_o;
    repeat (16) begin
      cyc(1);
      if (led_green_o !== g) n++;
      g = led_green_o;
    end
    chk(n > 1, 1'b1, "green flash");
    chain_input_a_i = 1'b1;
    cyc(10);
    chk(led_green_o, 1'b1, "green on");
    cyc(5);
    chk(led_green_o, 1'b1, "green steady");
    wait_chan(1'b1);
  endtask
  task automatic t_teach();
    actuator_present_i = 1'b0;
    pwr(1'b0);
    actuator_code_i = CODE_B;
    actuator_present_i = 1'b1;
    cyc(10);
    chk(led_red_o, 1'b1, "teach red");
    chk(led_green_o, 1'b0, "teach green");
    chk(safety_chan_a_o, 1'b0, "teach chan");
    wait_we();
    chk(store_valid_o, 1'b1, "candidate");
    pwr(1'b1);
    wait_we();
    chk(store_valid_o, 1'b1, "activated");
    chk(store_paired_o, 1'b1, "paired");
    chk(inhibit_pending_o, 1'b1, "inhibit");
    chk_code(store_code_o, CODE_B);
    cyc(20);
    chk(safety_chan_a_o, 1'b0, "inhibit off");
    pwr(1'b1);
    cyc(INH - 8);
    chk(safety_chan_a_o, 1'b0, "inhibit restart");
    wait_chan(1'b1);
    chk(safety_chan_a_o, 1'b1, "after inhibit");
  endtask
  task automatic t_abort();
    actuator_present_i = 1'b0;
    pwr(1'b0);
    actuator_code_i = CODE_A;
    actuator_present_i = 1'b1;
    wait_we();
    chk(store_valid_o, 1'b1, "reteach");
    wait_we();
    for (int i = 0; i < 40 && led_red_o === 1'b1; i++) cyc(1);
    chk(led_red_o, 1'b0, "abort flash");
    rst_i = 1'b1;
    stored_code_i = CODE_A;
    stored_valid_i = 1'b1;
    paired_i = 1'b1;
    inhibit_pending_i = 1'b0;
    pwr(1'b1);
    wait_chan(1'b1);
    critical_error_i = 1'b1;
    cyc(8);
    chk(safety_chan_a_o, 1'b0, "critical");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_i, ce_i, individual_coding_i, paired_i} = 4'hf;
    {stored_valid_i, inhibit_pending_i, actuator_present_i} = 3'h5;
    {guard_closed_i, rel_req, chain_input_a_i, chain_input_b_i} = 4'hb;
    {noncrit_error_i, critical_error_i} = 2'h0;
    stored_code_i = CODE_A;
    actuator_code_i = CODE_A;
    pwr(1'b1);
    t_enable();
    t_unlock();
    t_wrong();
    t_warn();
    t_green();
    t_teach();
    t_abort();
    give_verdict();
  end
endmodule // glk_guard_lock_tb
